/* File: rtl/pmcg_top.sv */
// power mode sequencer with clock gating and lock-loss handling
// What this block does
// - in run mode unit clocks follow software unit enables and unit demand
// - idle entry gates processor clock off until a wake condition
// - idle is entered only on software request with no pending work
// - peripherals stay clocked during idle
// - peripheral access to processor-local memory served during idle
// - wake from idle on reset, watchdog, nmi falling edge, enabled irq
// - deep sleep stops system clock; only external wake restarts
// - deep sleep entry runs an ordered shutdown sequence
// - idle or unneeded units are gated automatically, reenabled on demand
// - loss of pll lock outside sleep and the lock wait triggers emergency handling
`timescale 1ns/1ps
`include "pmcg_consts.svh"
module pmcg_top (
  // clock and reset
  input  wire logic                 CLK_SYS_IN,
  input  wire logic                 RST_IN,
  // software requests, same clock
  input  wire logic                 IDLE_REQ_IN,
  input  wire logic                 SLEEP_REQ_IN,
  input  wire logic                 CPU_BUSY_IN,
  input  wire pmcg_pkg::pmcg_units_t UNIT_EN_IN,
  input  wire pmcg_pkg::pmcg_units_t UNIT_BUSY_IN,
  // wake sources, same clock
  input  wire logic                 WDT_EVENT_IN,
  input  wire logic                 IRQ_PEND_IN,
  // pins from outside
  input  wire logic                 NMI_PIN_N_IN,
  input  wire logic                 EXT_WAKE_IN,
  input  wire logic                 PLL_LOCK_IN,
  // clock gate and mode outputs
  output pmcg_pkg::pmcg_gate_s      GATE_OUT,
  output pmcg_pkg::pmcg_units_t     UNIT_CLK_EN_OUT,
  output pmcg_pkg::pmcg_state_e     MODE_OUT
);
  import pmcg_pkg::*;

  logic [2:0]  pin_sync;
  logic        nmi_n_s;
  logic        ext_wake_s;
  logic        lock_s;
  logic        nmi_n_prev_reg;
  logic        nmi_fall;
  logic        lock_prev_reg;
  logic        lock_lost;
  logic [7:0]  step_reg;
  logic [7:0]  lockw_reg;
  logic        step_done;
  pmcg_state_e state_reg;
  pmcg_state_e state_next;

  // pins pass two flops before use; nmi goes in inverted so the cleared
  // synchroniser matches the idle pin and no false edge follows reset
  pmcg_sync #(.W(3)) u_sync (
    .clk_in (CLK_SYS_IN),
    .rst_in (RST_IN),
    .d_in   ({~NMI_PIN_N_IN, EXT_WAKE_IN, PLL_LOCK_IN}),
    .q_out  (pin_sync)
  );
  assign nmi_n_s    = ~pin_sync[2];
  assign ext_wake_s = pin_sync[1];
  assign lock_s     = pin_sync[0];

  // edge detectors on synchronised levels
  always_ff @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      nmi_n_prev_reg <= 1'b1;
      lock_prev_reg  <= 1'b0;
    end else begin
      nmi_n_prev_reg <= nmi_n_s;
      lock_prev_reg  <= lock_s;
    end
  end
  assign nmi_fall  = nmi_n_prev_reg & ~nmi_n_s;
  assign lock_lost = lock_prev_reg & ~lock_s;

  // step timer for sequence phases
  // restarts on every state change, so each phase gets its full count
  always_ff @(posedge CLK_SYS_IN) begin
    if (RST_IN || state_next != state_reg) begin
      step_reg <= 8'h00;
    end else if (step_reg != 8'hff) begin
      step_reg <= step_reg + 8'h01;
    end
  end
  assign step_done = (step_reg >= `PMCG_STEP_CYC - 8'h01);

  // minimum wait for lock after restart, bounded by lock input
  // a lock flag still high from before sleep is not trusted on its own
  always_ff @(posedge CLK_SYS_IN) begin
    if (RST_IN || state_reg != PMCG_WU_LOCK) begin
      lockw_reg <= 8'h00;
    end else if (lockw_reg != 8'hff) begin
      lockw_reg <= lockw_reg + 8'h01;
    end
  end

  // mode sequencer
  // sleep wins over idle when both are asked in the same cycle
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      PMCG_RUN: begin
        if (SLEEP_REQ_IN && !CPU_BUSY_IN) begin
          state_next = PMCG_SD_UNITS;
        end else if (IDLE_REQ_IN && !CPU_BUSY_IN) begin
          state_next = PMCG_IDLE;
        end
      end
      PMCG_IDLE: begin
        if (WDT_EVENT_IN || nmi_fall || IRQ_PEND_IN) begin
          state_next = PMCG_RUN;
        end
      end
      PMCG_SD_UNITS: if (step_done) state_next = PMCG_SD_CPU;
      PMCG_SD_CPU:   if (step_done) state_next = PMCG_SLEEP;
      PMCG_SLEEP:    if (ext_wake_s) state_next = PMCG_WU_LOCK;
      PMCG_WU_LOCK: begin
        if (lock_s && lockw_reg >= 8'(`PMCG_LOCK_CYC)) state_next = PMCG_WU_CPU;
      end
      PMCG_WU_CPU:   if (step_done) state_next = PMCG_WU_UNITS;
      PMCG_WU_UNITS: if (step_done) state_next = PMCG_RUN;
    endcase
  end

  // state register
  always_ff @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      state_reg <= PMCG_RUN;  // reset is also a wake from idle
    end else begin
      state_reg <= state_next;
    end
  end

  // gate outputs registered from next state
  // so every gate changes at the same edge as the state itself
  always_ff @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      GATE_OUT <= '{cpu_clk_en: 1'b1, sys_clk_en: 1'b1, mem_port_en: 1'b1, emergency: 1'b0};
    end else begin
      GATE_OUT.cpu_clk_en  <= (state_next == PMCG_RUN) || (state_next == PMCG_SD_UNITS)
                              || (state_next == PMCG_WU_UNITS);
      GATE_OUT.sys_clk_en  <= (state_next != PMCG_SLEEP)
                              && (state_next != PMCG_WU_LOCK);
      GATE_OUT.mem_port_en <= (state_next != PMCG_SLEEP);
      // emergency is sticky until reset; lock loss outside sleep and the lock wait is a fault
      if (lock_lost && state_reg != PMCG_SLEEP && state_reg != PMCG_WU_LOCK) begin
        GATE_OUT.emergency <= 1'b1;
      end
    end
  end

  // unit clocks: software enable and demand, same rule in idle as in run
  // demand gating costs one cycle of latency when a unit wakes
  always_ff @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      UNIT_CLK_EN_OUT <= `PMCG_UNIT_EN_RST;
    end else begin
      unique case (state_next)
        PMCG_RUN, PMCG_IDLE: UNIT_CLK_EN_OUT <= UNIT_EN_IN & UNIT_BUSY_IN;
        PMCG_WU_UNITS:       UNIT_CLK_EN_OUT <= UNIT_EN_IN & UNIT_BUSY_IN;
        default:             UNIT_CLK_EN_OUT <= '0;
      endcase
    end
  end

  // mode code for software, in step with the gates
  always_ff @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      MODE_OUT <= PMCG_RUN;
    end else begin
      MODE_OUT <= state_next;
    end
  end

  // assertions
  idle_cpu_off_a: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
    state_reg == PMCG_IDLE |-> !GATE_OUT.cpu_clk_en)
    else $error("cpu clock running in idle");
  idle_entry_a: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
    $rose(state_reg == PMCG_IDLE) |-> $past(IDLE_REQ_IN) && !$past(CPU_BUSY_IN))
    else $error("idle entered without request");
  idle_mem_a: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
    state_reg == PMCG_IDLE |-> GATE_OUT.mem_port_en && GATE_OUT.sys_clk_en)
    else $error("memory port closed in idle");
  idle_wake_a: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
    state_reg == PMCG_IDLE && (WDT_EVENT_IN || IRQ_PEND_IN) |=> state_reg == PMCG_RUN)
    else $error("idle did not wake");
  sleep_clk_a: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
    state_reg == PMCG_SLEEP && !ext_wake_s |=> state_reg == PMCG_SLEEP && !GATE_OUT.sys_clk_en)
    else $error("sleep left without wake");
  shutdown_order_a: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
    $rose(state_reg == PMCG_SLEEP) |-> $past(state_reg) == PMCG_SD_CPU)
    else $error("sleep entered out of order");
  lock_emerg_a: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
    lock_lost && state_reg == PMCG_RUN |=> GATE_OUT.emergency)
    else $error("lock loss not flagged");
  wake_order_a: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
    state_reg == PMCG_WU_LOCK && state_next == PMCG_WU_CPU |=> ##[1:3] state_reg == PMCG_WU_UNITS)
    else $error("wake order broken");
  unit_gate_a: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
    state_reg == PMCG_RUN && state_next == PMCG_RUN
      |=> UNIT_CLK_EN_OUT == $past(UNIT_EN_IN & UNIT_BUSY_IN))
    else $error("unit gating wrong");
  run_clk_a: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
    state_reg == PMCG_RUN |-> GATE_OUT.cpu_clk_en && GATE_OUT.sys_clk_en
      && GATE_OUT.mem_port_en)
    else $error("clock off in run");
  idle_units_a: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
    state_reg == PMCG_IDLE && state_next == PMCG_IDLE
      |=> UNIT_CLK_EN_OUT == $past(UNIT_EN_IN & UNIT_BUSY_IN))
    else $error("units not kept in idle");
  nmi_wake_a: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
    state_reg == PMCG_IDLE && nmi_fall |=> state_reg == PMCG_RUN)
    else $error("nmi edge did not wake");
  sd_units_a: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
    state_reg == PMCG_SD_UNITS |-> UNIT_CLK_EN_OUT == 4'h0 && GATE_OUT.cpu_clk_en)
    else $error("units not stopped first");
  idle_cov_c:  cover property (@(posedge CLK_SYS_IN)
    state_reg == PMCG_IDLE ##1 state_reg == PMCG_RUN);
  sleep_cov_c: cover property (@(posedge CLK_SYS_IN)
    state_reg == PMCG_SLEEP ##1 state_reg == PMCG_WU_LOCK);
  emerg_cov_c: cover property (@(posedge CLK_SYS_IN) $rose(GATE_OUT.emergency));
  nmi_cov_c:   cover property (@(posedge CLK_SYS_IN) state_reg == PMCG_IDLE && nmi_fall);
  wake_cov_c:  cover property (@(posedge CLK_SYS_IN)
    state_reg == PMCG_WU_UNITS ##1 state_reg == PMCG_RUN);
endmodule

/* File: rtl/pmcg_consts.svh */
// constants for the power mode and clock gating block
`ifndef PMCG_CONSTS_SVH
`define PMCG_CONSTS_SVH
`define PMCG_NUM_UNITS      4
`define PMCG_IDLE_HOLD_CYC  8'h04
`define PMCG_STEP_CYC       8'h02
`define PMCG_LOCK_TIME_NS   1000
`define PMCG_CLK_PERIOD_NS  100
`define PMCG_LOCK_CYC       ((`PMCG_LOCK_TIME_NS + `PMCG_CLK_PERIOD_NS - 1) / `PMCG_CLK_PERIOD_NS)
`define PMCG_UNIT_EN_RST    4'hf
`endif

/* File: rtl/pmcg_pkg.sv */
// types for the power mode and clock gating block
package pmcg_pkg;
  typedef enum logic [2:0] {
    PMCG_RUN      = 3'b000,
    PMCG_IDLE     = 3'b001,
    PMCG_SD_UNITS = 3'b010,
    PMCG_SD_CPU   = 3'b011,
    PMCG_SLEEP    = 3'b100,
    PMCG_WU_LOCK  = 3'b101,
    PMCG_WU_CPU   = 3'b110,
    PMCG_WU_UNITS = 3'b111
  } pmcg_state_e;
  typedef struct packed {
    logic cpu_clk_en;
    logic sys_clk_en;
    logic mem_port_en;
    logic emergency;
  } pmcg_gate_s;
  typedef logic [3:0] pmcg_units_t;
endpackage

/* File: rtl/pmcg_sync.sv */
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module pmcg_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] meta_reg;
  // first stage read only by the second
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      meta_reg <= '0;
      q_out    <= '0;
    end else begin
      meta_reg <= d_in;
      q_out    <= meta_reg;
    end
  end
endmodule

/* File: test/pmcg_top_tb.sv */
// self-checking bench for the power mode and clock gating block
`timescale 1ns/1ps
module pmcg_top_tb;
  import pmcg_pkg::*;
  logic        clk, rst, idle_req, sleep_req, cpu_busy, wdt, irq, nmi_n, ext_wake, pll_lock;
  pmcg_units_t unit_en, unit_busy, unit_clk;
  pmcg_gate_s  gate;
  pmcg_state_e mode;
  int          fail_count = 0;
  int          tests_run = 0;
  pmcg_top uut (.CLK_SYS_IN(clk), .RST_IN(rst), .IDLE_REQ_IN(idle_req),
    .SLEEP_REQ_IN(sleep_req), .CPU_BUSY_IN(cpu_busy), .UNIT_EN_IN(unit_en),
    .UNIT_BUSY_IN(unit_busy), .WDT_EVENT_IN(wdt), .IRQ_PEND_IN(irq),
    .NMI_PIN_N_IN(nmi_n), .EXT_WAKE_IN(ext_wake), .PLL_LOCK_IN(pll_lock),
    .GATE_OUT(gate), .UNIT_CLK_EN_OUT(unit_clk), .MODE_OUT(mode));
  // 10 mhz system clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // bounded wait, judged by whether the mode was reached
  task automatic wait_mode(pmcg_state_e m, int lim);
    int n;
    n = 0;
    #1;
    while (mode !== m && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
    check("mode", mode, m);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic do_reset(int cyc);
    @(posedge clk) rst <= 1'b1;
    repeat (cyc) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    check("rst_gate", gate, 4'he);
    check("rst_units", unit_clk, 4'hf);
    check("rst_mode", mode, PMCG_RUN);
  endtask
  // unit clocks follow enable and demand; cpu stays clocked in run
  task automatic t_units();
    for (int i = 0; i < 4; i++) begin
      @(posedge clk) unit_en <= 4'h5 << i;
      unit_busy <= 4'hc >> i;
      repeat (2) @(posedge clk);
      #1;
      check("units", unit_clk, (4'h5 << i) & (4'hc >> i));
      check("run_cpu", gate.cpu_clk_en, 1'b1);
    end
  endtask
  // busy processor makes both requests go unheard
  task automatic t_refuse();
    @(posedge clk) cpu_busy <= 1'b1;
    idle_req <= 1'b1;
    sleep_req <= 1'b1;
    repeat (6) @(posedge clk);
    #1;
    check("busy_mode", mode, PMCG_RUN);
    @(posedge clk) idle_req <= 1'b0;
    sleep_req <= 1'b0;
    cpu_busy <= 1'b0;
  endtask
  // enter idle, then leave by source 0 irq, 1 wdt, 2 nmi edge, 3 reset
  task automatic t_idle(int src);
    @(posedge clk) idle_req <= 1'b1;
    unit_en <= 4'hb;
    unit_busy <= 4'h6;
    @(posedge clk) idle_req <= 1'b0;
    wait_mode(PMCG_IDLE, 3);
    repeat (4) @(posedge clk);
    #1;
    check("idle_mode", mode, PMCG_IDLE);
    check("idle_gate", gate, 4'h6);
    check("idle_units", unit_clk, unit_en & unit_busy);
    @(posedge clk);
    case (src)
      0: irq <= 1'b1;
      1: wdt <= 1'b1;
      2: nmi_n <= 1'b0;
      default: rst <= 1'b1;
    endcase
    wait_mode(PMCG_RUN, 6);
    check("wake_cpu", gate.cpu_clk_en, 1'b1);
    @(posedge clk) irq <= 1'b0;
    wdt <= 1'b0;
    nmi_n <= 1'b1;
    rst <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  // ordered shutdown, deaf sleep, ordered restart after lock
  task automatic t_sleep();
    @(posedge clk) sleep_req <= 1'b1;
    unit_en <= 4'hf;
    unit_busy <= 4'hf;
    @(posedge clk) sleep_req <= 1'b0;
    wait_mode(PMCG_SD_UNITS, 3);
    check("sd_units", unit_clk, 4'h0);
    wait_mode(PMCG_SD_CPU, 4);
    check("sd_cpu", gate.cpu_clk_en, 1'b0);
    wait_mode(PMCG_SLEEP, 4);
    check("sleep_gate", gate, 4'h0);
    @(posedge clk) irq <= 1'b1;
    wdt <= 1'b1;
    pll_lock <= 1'b0;
    repeat (20) @(posedge clk);
    #1;
    check("sleep_stay", mode, PMCG_SLEEP);
    check("sleep_hold", gate, 4'h0);
    @(posedge clk) irq <= 1'b0;
    wdt <= 1'b0;
    ext_wake <= 1'b1;
    wait_mode(PMCG_WU_LOCK, 5);
    @(posedge clk) ext_wake <= 1'b0;
    repeat (15) @(posedge clk);
    #1;
    check("lock_wait", mode, PMCG_WU_LOCK);
    @(posedge clk) pll_lock <= 1'b1;
    wait_mode(PMCG_WU_CPU, 6);
    check("wu_cpu_units", unit_clk, 4'h0);
    check("wu_cpu_sys", gate.sys_clk_en, 1'b1);
    wait_mode(PMCG_WU_UNITS, 4);
    check("wu_cpu", gate.cpu_clk_en, 1'b1);
    wait_mode(PMCG_RUN, 4);
    check("wu_gate", gate, 4'he);
    check("wu_units", unit_clk, 4'hf);
  endtask
  // lock loss in run raises a sticky emergency
  task automatic t_lock();
    int n;
    @(posedge clk) pll_lock <= 1'b0;
    n = 0;
    while (gate.emergency !== 1'b1 && n < 6) begin
      @(posedge clk);
      #1;
      n++;
    end
    check("emerg", gate.emergency, 1'b1);
    @(posedge clk) pll_lock <= 1'b1;
    repeat (5) @(posedge clk);
    #1;
    check("emerg_hold", gate.emergency, 1'b1);
    do_reset(3);
  endtask
  // hang guard, far beyond the expected run length
  initial begin
    #(5000 * 100);
    fail_count++;
    summarize();
  end
  initial begin
    {rst, idle_req, sleep_req, cpu_busy, wdt, irq, ext_wake} = '0;
    nmi_n = 1'b1;
    pll_lock = 1'b1;
    unit_en = 4'hf;
    unit_busy = 4'hf;
    rst = 1'b1;
    repeat (12) @(posedge clk);
    do_reset(1);
    t_units();
    t_refuse();
    for (int s = 0; s < 4; s++) t_idle(s);
    t_sleep();
    t_lock();
    summarize();
  end
endmodule
